// ### src/nt1_pin_control_status.sv
`timescale 1ns/1ns
module nt1_pin_control_status
  import nt1_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // strap and control pins
  input  wire logic               cold_start_only,
  input  wire logic               act_timer_expired,
  input  wire logic [3:0]         sample_point_sel,
  input  wire logic               ext_sampling_select,
  input  wire logic [SLICE_W-1:0] slice_ref_pos,
  input  wire logic [SLICE_W-1:0] slice_ref_neg,
  input  wire logic               full_reset_req,
  input  wire logic               full_reset_enable,
  input  wire logic               test_mode_n,
  input  wire logic [2:0]         test_sel,
  input  wire logic               u_only_enable,
  input  wire logic               st_only_activation_n,
  input  wire logic               actbit_map_sel,
  input  wire logic               rx_timing_sel,
  input  wire logic               st_loop_b1_n,
  input  wire logic               st_loop_b2_n,
  input  wire logic               internal_st_select,
  input  wire logic               operation_mode_sel,
  input  wire logic               pwr_status_a,
  input  wire logic               pwr_status_b,
  input  wire logic               recovered_clk_80,
  // transceiver core
  input  wire core_in_t           core_in,
  output core_ctrl_t              core_ctrl,
  // indicator pins
  output logic                    act_timer_enable,
  output logic                    mchan_valid,
  output logic                    u_side_ready,
  output logic                    st_side_ready,
  output logic                    test_indicator,
  output logic                    loop2_indicator,
  output logic                    status_out_a,
  output logic                    status_out_b,
  output logic                    status_frame_pulse,
  output logic                    st_tx_clock,
  output logic                    st_tx_pos
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  strap_t strap_s1_q;
  strap_t strap_q;
  logic   clk80_s1_q;
  logic   clk80_q;
  logic   clk80_prev_q;
  strap_t strap_raw;

  assign strap_raw = '{cold_start_only, act_timer_expired, sample_point_sel,
                       ext_sampling_select, slice_ref_pos, slice_ref_neg,
                       full_reset_req, full_reset_enable, test_mode_n, test_sel,
                       u_only_enable, st_only_activation_n, actbit_map_sel,
                       rx_timing_sel, st_loop_b1_n, st_loop_b2_n,
                       internal_st_select, operation_mode_sel, pwr_status_a,
                       pwr_status_b};

  // first stage is read by the second stage only
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_s1_q   <= STRAP_RST;
      strap_q      <= STRAP_RST;
      clk80_s1_q   <= 1'b0;
      clk80_q      <= 1'b0;
      clk80_prev_q <= 1'b0;
    end else begin
      strap_s1_q   <= strap_raw;
      strap_q      <= strap_s1_q;
      clk80_s1_q   <= recovered_clk_80;
      clk80_q      <= clk80_s1_q;
      clk80_prev_q <= clk80_q;
    end
  end

  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  logic       hw_mode;
  logic       ntm_run;
  logic       full_reset;
  logic       st_forced;
  logic       u_in_ready_state;
  logic       act_m4;
  logic       ps_a_m4;
  logic       ps_b_m4;
  core_ctrl_t ctrl_d;

  assign hw_mode    = strap_q.operation_mode_sel;
  assign ntm_run    = strap_q.test_mode_n;
  assign full_reset = strap_q.full_reset_enable & strap_q.full_reset_req;
  // in hardware mode any of the three low-active pins pulls s/t into G3
  assign st_forced  = ~strap_q.st_only_activation_n
                    | ~strap_q.st_loop_b1_n
                    | ~strap_q.st_loop_b2_n;

  always_comb begin
    case (core_in.state)
      U_H6, U_H6A, U_H7, U_H8, U_H8A,
      U_H8B, U_H8C, U_H9, U_H11: u_in_ready_state = 1'b1;
      default:                   u_in_ready_state = 1'b0;
    endcase
  end

  // during loop 2 the act bit follows the selected convention
  always_comb begin
    if (core_in.loop2) begin
      act_m4 = strap_q.actbit_map_sel;
    end else begin
      act_m4 = core_in.act_req;
    end
  end

  // power status reported only when enabled, else reads as normal power
  assign ps_a_m4 = (ntm_run & strap_q.test_sel[1]) ? strap_q.pwr_status_a : 1'b1;
  assign ps_b_m4 = (ntm_run & strap_q.test_sel[1]) ? strap_q.pwr_status_b : 1'b1;

  always_comb begin
    ctrl_d                 = '0;
    ctrl_d.force_h1        = full_reset;
    ctrl_d.st_force_g3     = hw_mode & st_forced;
    ctrl_d.u_attempt_act   = st_forced & ~u_in_ready_state;
    ctrl_d.poweron_act_en  = ntm_run & strap_q.test_sel[0];
    ctrl_d.pwr_report_en   = ntm_run & strap_q.test_sel[1];
    ctrl_d.h6_skip_act     = ntm_run & ~strap_q.test_sel[2];
    ctrl_d.ignore_dea      = ntm_run & ~strap_q.test_sel[2];
    ctrl_d.u_only_act      = strap_q.u_only_enable & core_in.rx_uoa;
    ctrl_d.loop_b1         = hw_mode & ~strap_q.st_loop_b1_n;
    ctrl_d.loop_b2         = hw_mode & ~strap_q.st_loop_b2_n;
    ctrl_d.adaptive_timing = strap_q.rx_timing_sel;
    ctrl_d.ext_sampling    = strap_q.ext_sampling_select;
    if (strap_q.ext_sampling_select) begin
      ctrl_d.sample_point  = strap_q.sample_point_sel;
      ctrl_d.slice_pos     = strap_q.slice_ref_pos;
      ctrl_d.slice_neg     = strap_q.slice_ref_neg;
    end else begin
      ctrl_d.sample_point  = SAMPLE_DEFAULT;
    end
    ctrl_d.local_test_en   = ~ntm_run;
    ctrl_d.local_test_sel  = ntm_run ? 3'h0 : strap_q.test_sel;
    ctrl_d.cold_start      = strap_q.cold_start_only;
    ctrl_d.timer_expired   = strap_q.act_timer_expired;
    ctrl_d.hw_mode         = hw_mode;
    ctrl_d.m4.cso          = strap_q.cold_start_only;
    ctrl_d.m4.ntm          = strap_q.test_mode_n;
    ctrl_d.m4.ps1          = ps_a_m4;
    ctrl_d.m4.ps2          = ps_b_m4;
    ctrl_d.m4.act          = act_m4;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      core_ctrl <= '0;
    end else begin
      core_ctrl <= ctrl_d;
    end
  end

  // ----------------------------------------
  // indicator pins
  // ----------------------------------------
  logic u_ready_d;
  logic st_ready_d;
  logic test_ind_d;

  assign u_ready_d  = u_in_ready_state & ~core_in.los & ~core_in.sync_lost;
  // serial mode has no s/t side, so it can never report ready
  assign st_ready_d = hw_mode & core_in.st_info3_rx & core_in.st_info4_tx;
  assign test_ind_d = core_in.remote_lb | core_in.maint | ~ntm_run | full_reset;

  always_ff @(posedge mclk) begin
    if (rst) begin
      u_side_ready <= 1'b0;
    end else begin
      u_side_ready <= u_ready_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_side_ready <= 1'b0;
    end else begin
      st_side_ready <= st_ready_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      test_indicator <= 1'b0;
    end else begin
      test_indicator <= test_ind_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      loop2_indicator <= 1'b0;
    end else begin
      loop2_indicator <= core_in.loop2;
    end
  end

  // timer start and serial valid are never both high: the mode picks one
  always_ff @(posedge mclk) begin
    if (rst) begin
      act_timer_enable <= 1'b0;
    end else begin
      act_timer_enable <= hw_mode & core_in.timer_start;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mchan_valid <= 1'b0;
    end else begin
      mchan_valid <= ~hw_mode & core_in.isw_sync;
    end
  end

  // ----------------------------------------
  // s/t transmit pins
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_tx_clock <= 1'b0;
    end else begin
      st_tx_clock <= hw_mode & core_in.st_bit_clk;
    end
  end

  // internal driver in use, so the digital output stays quiet
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_tx_pos <= 1'b0;
    end else begin
      st_tx_pos <= hw_mode & ~strap_q.internal_st_select & core_in.tx_pos;
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic        acc;
  logic        wr_ev;
  logic        mapped;
  logic [31:0] rd_mux;

  assign acc    = psel & penable & ~pready;
  assign wr_ev  = psel & penable & pready & pwrite;
  assign mapped = (paddr == REG_CTRL) | (paddr == REG_STRAP) | (paddr == REG_STATE);

  always_comb begin
    case (paddr)
      REG_CTRL:  rd_mux = ctrl_q;
      REG_STRAP: rd_mux = {1'b0, strap_q};
      REG_STATE: rd_mux = {16'h0000, core_in.state, 3'h0, core_ctrl.m4,
                           test_indicator, loop2_indicator, st_side_ready,
                           u_side_ready};
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ev && paddr == REG_CTRL) begin
      ctrl_q <= {31'h0000_0000, pwdata[CTRL_STAT_EN_BIT]};
    end
  end

  // ----------------------------------------
  // serial status words
  // ----------------------------------------
  logic                   clk80_fall;
  logic [2:0]             bit_cnt_q;
  logic [STAT_WORD_W-1:0] word_a_q;
  logic [STAT_WORD_W-1:0] word_b_q;
  logic [STAT_WORD_W-1:0] snap_a;
  logic [STAT_WORD_W-1:0] snap_b;
  logic                   stat_en;

  assign clk80_fall = clk80_prev_q & ~clk80_q;
  assign stat_en    = ctrl_q[CTRL_STAT_EN_BIT];
  assign snap_a     = {u_side_ready, st_side_ready, loop2_indicator, test_indicator,
                       act_timer_enable, strap_q.cold_start_only,
                       strap_q.pwr_status_a, strap_q.pwr_status_b};
  assign snap_b     = {core_in.state, core_in.los, core_in.sync_lost,
                       core_in.st_info3_rx, core_in.st_info4_tx};

  // a word is captured whole so its bits stay coherent across 8 periods
  always_ff @(posedge mclk) begin
    if (rst || !stat_en) begin
      bit_cnt_q          <= STAT_LAST_BIT;
      word_a_q           <= '0;
      word_b_q           <= '0;
      status_out_a       <= 1'b0;
      status_out_b       <= 1'b0;
      status_frame_pulse <= 1'b0;
    end else if (clk80_fall) begin
      if (bit_cnt_q == STAT_LAST_BIT) begin
        bit_cnt_q          <= 3'h0;
        status_out_a       <= snap_a[STAT_WORD_W-1];
        status_out_b       <= snap_b[STAT_WORD_W-1];
        word_a_q           <= {snap_a[STAT_WORD_W-2:0], 1'b0};
        word_b_q           <= {snap_b[STAT_WORD_W-2:0], 1'b0};
        status_frame_pulse <= 1'b1;
      end else begin
        bit_cnt_q          <= bit_cnt_q + 3'h1;
        status_out_a       <= word_a_q[STAT_WORD_W-1];
        status_out_b       <= word_b_q[STAT_WORD_W-1];
        word_a_q           <= {word_a_q[STAT_WORD_W-2:0], 1'b0};
        word_b_q           <= {word_b_q[STAT_WORD_W-2:0], 1'b0};
        status_frame_pulse <= 1'b0;
      end
    end
  end

endmodule // nt1_pin_control_status

// ### inc/nt1_pkg.sv
package nt1_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STRAP  = 8'h04;
  localparam logic [7:0]  REG_STATE  = 8'h08;
  localparam int          CTRL_STAT_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;

  // ----------------------------------------
  // widths and counts
  // ----------------------------------------
  localparam int         SLICE_W        = 4;
  localparam int         STAT_WORD_W    = 8;
  localparam logic [2:0] STAT_LAST_BIT  = 3'h7;
  localparam logic [3:0] SAMPLE_DEFAULT = 4'h8;

  // ----------------------------------------
  // u activation states
  // ----------------------------------------
  typedef enum logic [3:0] {
    U_H1    = 4'b0000, U_H2  = 4'b0001, U_H3  = 4'b0010, U_H4  = 4'b0011,
    U_H5    = 4'b0100, U_H6  = 4'b0101, U_H6A = 4'b0110, U_H7  = 4'b0111,
    U_H8    = 4'b1000, U_H8A = 4'b1001, U_H8B = 4'b1010, U_H8C = 4'b1011,
    U_H9    = 4'b1100, U_H10 = 4'b1101, U_H11 = 4'b1110, U_HX  = 4'b1111
  } u_state_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic               cold_start_only;
    logic               act_timer_expired;
    logic [3:0]         sample_point_sel;
    logic               ext_sampling_select;
    logic [SLICE_W-1:0] slice_ref_pos;
    logic [SLICE_W-1:0] slice_ref_neg;
    logic               full_reset_req;
    logic               full_reset_enable;
    logic               test_mode_n;
    logic [2:0]         test_sel;
    logic               u_only_enable;
    logic               st_only_activation_n;
    logic               actbit_map_sel;
    logic               rx_timing_sel;
    logic               st_loop_b1_n;
    logic               st_loop_b2_n;
    logic               internal_st_select;
    logic               operation_mode_sel;
    logic               pwr_status_a;
    logic               pwr_status_b;
  } strap_t;

  localparam strap_t STRAP_RST = '{test_mode_n: 1'b1, st_only_activation_n: 1'b1,
                                   st_loop_b1_n: 1'b1, st_loop_b2_n: 1'b1,
                                   operation_mode_sel: 1'b1, default: '0};

  typedef struct packed {
    logic cso;
    logic ntm;
    logic ps1;
    logic ps2;
    logic act;
  } m4_t;

  typedef struct packed {
    u_state_t state;
    logic     los;
    logic     sync_lost;
    logic     isw_sync;
    logic     loop2;
    logic     remote_lb;
    logic     maint;
    logic     timer_start;
    logic     rx_uoa;
    logic     act_req;
    logic     st_info3_rx;
    logic     st_info4_tx;
    logic     st_bit_clk;
    logic     tx_pos;
  } core_in_t;

  typedef struct packed {
    logic               force_h1;
    logic               st_force_g3;
    logic               u_attempt_act;
    logic               poweron_act_en;
    logic               pwr_report_en;
    logic               h6_skip_act;
    logic               ignore_dea;
    logic               u_only_act;
    logic               loop_b1;
    logic               loop_b2;
    logic               adaptive_timing;
    logic               ext_sampling;
    logic [3:0]         sample_point;
    logic [SLICE_W-1:0] slice_pos;
    logic [SLICE_W-1:0] slice_neg;
    logic               local_test_en;
    logic [2:0]         local_test_sel;
    logic               cold_start;
    logic               timer_expired;
    logic               hw_mode;
    m4_t                m4;
  } core_ctrl_t;

endpackage

// ### tb/nt1_monitor.sv
`timescale 1ns/1ns
module nt1_monitor
  import nt1_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // apb handshake
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // strap pins
  input wire logic       full_reset_req,
  input wire logic       full_reset_enable,
  input wire logic       test_mode_n,
  input wire logic       st_only_activation_n,
  input wire logic       operation_mode_sel,
  // core and indicators
  input wire core_in_t   core_in,
  input wire core_ctrl_t core_ctrl,
  input wire logic       u_side_ready,
  input wire logic       st_side_ready,
  input wire logic       test_indicator,
  input wire logic       loop2_indicator,
  input wire logic       act_timer_enable,
  input wire logic       mchan_valid,
  input wire logic       status_frame_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic ur_exp;
  assign ur_exp = core_in.state inside {U_H6, U_H6A, U_H7, U_H8, U_H8A, U_H8B, U_H8C, U_H9, U_H11}
                  && !core_in.los && !core_in.sync_lost;
  // straps need three edges, so each strap relation waits for four stable samples
  a_u_ready_map: assert property (!$past(rst) |-> u_side_ready == $past(ur_exp))
    else $error("u ready does not follow state");
  a_st_ready_cause: assert property (st_side_ready |-> $past(core_in.st_info3_rx && core_in.st_info4_tx))
    else $error("st ready without info3 and info4");
  a_timer_en_cause: assert property (act_timer_enable |-> $past(core_in.timer_start))
    else $error("timer enable without start");
  a_valid_sync: assert property (mchan_valid |-> $past(core_in.isw_sync))
    else $error("valid without sync word lock");
  a_loop2_track: assert property (!$past(rst) |-> loop2_indicator == $past(core_in.loop2))
    else $error("loop2 indicator wrong");
  a_full_reset_h1: assert property ((full_reset_enable && full_reset_req) [*4] |->
    core_ctrl.force_h1 && test_indicator) else $error("full reset not applied");
  a_local_test_ind: assert property ((!test_mode_n) [*4] |->
    test_indicator && core_ctrl.local_test_en) else $error("local test not shown");
  a_g3_force_on: assert property ((!st_only_activation_n && operation_mode_sel) [*4] |->
    core_ctrl.st_force_g3) else $error("g3 not forced");
  a_frame_width: assert property ($rose(status_frame_pulse) |-> status_frame_pulse [*8])
    else $error("frame pulse too short");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
endmodule // nt1_monitor

// ### tb/nt1_far_model.sv
`timescale 1ns/1ns
module nt1_far_model #(
  parameter int TIMER_CYC    = 20,
  parameter bit TIMER_FITTED = 1'b1
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // external activation timer
  input  wire logic act_timer_enable,
  output logic      act_timer_expired,
  // recovered line clock
  output logic      recovered_clk_80
);
  int t_q;
  int c_q;
  always_ff @(posedge mclk) begin
    if (rst || !act_timer_enable) begin
      t_q <= 0;
    end else if (t_q < TIMER_CYC) begin
      t_q <= t_q + 1;
    end
  end
  // an absent timer leaves the pin low for good
  assign act_timer_expired = TIMER_FITTED && act_timer_enable && t_q == TIMER_CYC;
  // 125 mclk periods make one 80 kHz cycle; line clock runs free
  always_ff @(posedge mclk) begin
    c_q <= (rst || c_q == 124) ? 0 : c_q + 1;
  end
  assign recovered_clk_80 = c_q < 62;
endmodule // nt1_far_model

// ### tb/nt1_pin_control_status_tb_top.sv
`timescale 1ns/1ns
module nt1_pin_control_status_tb_top;
  import nt1_pkg::*;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, act_timer_enable, mchan_valid, u_side_ready, st_side_ready, test_indicator;
  logic loop2_indicator, status_out_a, status_out_b, status_frame_pulse, st_tx_clock, st_tx_pos;
  logic act_timer_expired, recovered_clk_80;
  strap_t s;
  core_in_t ci;
  core_ctrl_t cc;
  int error_cnt = 0, comparisons = 0, cyc_cnt = 0;
  always #50 mclk = ~mclk;
  nt1_pin_control_status DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cold_start_only(s.cold_start_only), .act_timer_expired, .sample_point_sel(s.sample_point_sel),
    .ext_sampling_select(s.ext_sampling_select), .slice_ref_pos(s.slice_ref_pos), .slice_ref_neg(s.slice_ref_neg),
    .full_reset_req(s.full_reset_req), .full_reset_enable(s.full_reset_enable), .test_mode_n(s.test_mode_n),
    .test_sel(s.test_sel), .u_only_enable(s.u_only_enable), .st_only_activation_n(s.st_only_activation_n),
    .actbit_map_sel(s.actbit_map_sel), .rx_timing_sel(s.rx_timing_sel), .st_loop_b1_n(s.st_loop_b1_n),
    .st_loop_b2_n(s.st_loop_b2_n), .internal_st_select(s.internal_st_select),
    .operation_mode_sel(s.operation_mode_sel), .pwr_status_a(s.pwr_status_a), .pwr_status_b(s.pwr_status_b),
    .recovered_clk_80, .core_in(ci), .core_ctrl(cc), .act_timer_enable, .mchan_valid, .u_side_ready,
    .st_side_ready, .test_indicator, .loop2_indicator, .status_out_a, .status_out_b, .status_frame_pulse,
    .st_tx_clock, .st_tx_pos);
  nt1_far_model u_far (.mclk, .rst, .act_timer_enable, .act_timer_expired, .recovered_clk_80);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int t = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1);
    chk("apb wait", 2, t);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset_apb;
    logic [31:0] r;
    logic e;
    chk("ready idle", 0, {u_side_ready, test_indicator, status_frame_pulse, act_timer_enable});
    apb(0, REG_CTRL, 0, r, e);
    chk("ctrl reset", CTRL_RST, r);
    apb(1, REG_STRAP, 32'hFFFF_FFFF, r, e);
    apb(0, REG_STRAP, 0, r, e);
    chk("strap ro", 32'(s), r);
    apb(0, 8'h0C, 0, r, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
    apb(1, REG_CTRL, 0, r, e);
    apb(0, REG_CTRL, 0, r, e);
    chk("ctrl rw", 0, r);
    apb(1, REG_CTRL, CTRL_RST, r, e);
    $display("test reset_apb done");
  endtask
  task automatic t_uready;
    logic x;
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      ci.state <= u_state_t'(i[3:0]);
      ci.los <= i[4];
      ci.sync_lost <= i[5];
      ci.loop2 <= i[0];
      cyc(2);
      x = u_state_t'(i[3:0]) inside {U_H6, U_H6A, U_H7, U_H8, U_H8A, U_H8B, U_H8C, U_H9, U_H11};
      chk("u ready", x && i[5:4] == 0, u_side_ready);
      chk("loop2 ind", i[0], loop2_indicator);
    end
    $display("test uready done");
  endtask
  task automatic t_test;
    @(posedge mclk);
    s.test_mode_n <= 1'b0;
    s.test_sel <= 3'h5;
    cyc(5);
    chk("local test", 4'hD, {cc.local_test_en, cc.local_test_sel});
    chk("lt ind", 2'b10, {test_indicator, cc.m4.ntm});
    @(posedge mclk);
    s.test_mode_n <= 1'b1;
    s.full_reset_req <= 1'b1;
    cyc(5);
    chk("fr alone", 0, {cc.force_h1, test_indicator});
    @(posedge mclk);
    s.full_reset_enable <= 1'b1;
    cyc(5);
    chk("fr h1", 2'b11, {cc.force_h1, test_indicator});
    @(posedge mclk);
    s.full_reset_enable <= 1'b0;
    ci.maint <= 1'b1;
    cyc(5);
    chk("maint ind", 2'b01, {cc.force_h1, test_indicator});
    @(posedge mclk);
    ci.maint <= 1'b0;
    ci.remote_lb <= 1'b1;
    cyc(2);
    chk("rlb ind", 1, test_indicator);
    @(posedge mclk);
    ci.remote_lb <= 1'b0;
    $display("test test_modes done");
  endtask
  task automatic t_opts(input logic v);
    @(posedge mclk);
    s.test_sel <= v ? 3'b011 : 3'b100;
    s.ext_sampling_select <= v;
    s.sample_point_sel <= 4'h3;
    s.slice_ref_pos <= 4'hA;
    s.slice_ref_neg <= 4'h5;
    {s.rx_timing_sel, s.cold_start_only, s.u_only_enable, s.actbit_map_sel} <= {4{v}};
    {s.st_only_activation_n, s.st_loop_b2_n, s.pwr_status_a, s.pwr_status_b} <= {v, v, 1'b0, 1'b1};
    ci.loop2 <= 1'b1;
    ci.act_req <= ~v;
    ci.rx_uoa <= 1'b1;
    cyc(5);
    chk("pwr on", v, cc.poweron_act_en);
    chk("ps map", v ? 3'b101 : 3'b011, {cc.pwr_report_en, cc.m4.ps1, cc.m4.ps2});
    chk("h6 skip", {v, v}, {cc.h6_skip_act, cc.ignore_dea});
    chk("samp", v ? 12'h3A5 : {SAMPLE_DEFAULT, 8'h00}, {cc.sample_point, cc.slice_pos, cc.slice_neg});
    chk("adapt", v, cc.adaptive_timing);
    chk("cso", {v, v}, {cc.cold_start, cc.m4.cso});
    chk("uoa", v, cc.u_only_act);
    chk("g3", {~v, ~v}, {cc.st_force_g3, cc.u_attempt_act});
    chk("slb", {1'b0, ~v}, {cc.loop_b1, cc.loop_b2});
    chk("act map", v, cc.m4.act);
    $display("test opts done");
  endtask
  task automatic t_modes;
    @(posedge mclk);
    {ci.loop2, ci.timer_start, ci.st_info3_rx, ci.st_info4_tx, ci.st_bit_clk, ci.tx_pos, ci.isw_sync} <= 7'h3F;
    cyc(3);
    chk("hw pins", 5'h1E, {act_timer_enable, st_side_ready, st_tx_clock, st_tx_pos, mchan_valid});
    cyc(30);
    chk("expired", 1, cc.timer_expired);
    @(posedge mclk);
    s.internal_st_select <= 1'b1;
    cyc(5);
    chk("tx pos low", 0, st_tx_pos);
    @(posedge mclk);
    s.operation_mode_sel <= 1'b0;
    cyc(5);
    chk("serial", 4'h1, {act_timer_enable, st_side_ready, cc.hw_mode, mchan_valid});
    @(posedge mclk);
    s.operation_mode_sel <= 1'b1;
    ci.isw_sync <= 1'b0;
    $display("test modes done");
  endtask
  task automatic wait_pulse;
    int t = 0;
    while (status_frame_pulse !== 1'b0 && t < 2000) begin
      @(posedge mclk);
      t++;
    end
    while (status_frame_pulse !== 1'b1 && t < 2000) begin
      @(posedge mclk);
      t++;
    end
    if (t >= 2000) chk("frame", 1, 0);
  endtask
  task automatic t_status;
    logic [7:0] a, b;
    logic [31:0] r;
    logic e;
    @(posedge mclk);
    ci.state <= U_H7;
    {ci.los, ci.sync_lost, ci.loop2} <= 3'b000;
    {s.cold_start_only, s.pwr_status_a, s.pwr_status_b} <= 3'b101;
    cyc(5);
    wait_pulse();
    wait_pulse();
    cyc(60);
    for (int k = 7; k >= 0; k--) begin
      a[k] = status_out_a;
      b[k] = status_out_b;
      chk("frame bit", k == 7, status_frame_pulse);
      cyc(125);
    end
    chk("word a", {1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1}, a);
    chk("word b", {4'(U_H7), 4'b0011}, b);
    apb(1, REG_CTRL, 0, r, e);
    cyc(300);
    chk("stat off", 0, {status_frame_pulse, status_out_a, status_out_b});
    $display("test status done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    s = STRAP_RST;
    ci = '0;
    cyc(4); // power-up reset from the controlling side
    rst <= 1'b0;
    t_reset_apb();
    t_uready();
    t_test();
    t_opts(1'b1);
    t_opts(1'b0);
    t_modes();
    t_status();
    give_verdict();
  end
endmodule // nt1_pin_control_status_tb_top
bind nt1_pin_control_status nt1_monitor u_mon (.mclk, .rst, .psel, .penable, .pready, .full_reset_req,
  .full_reset_enable, .test_mode_n, .st_only_activation_n, .operation_mode_sel, .core_in, .core_ctrl,
  .u_side_ready, .st_side_ready, .test_indicator, .loop2_indicator, .act_timer_enable, .mchan_valid,
  .status_frame_pulse);
